// *** hdl/pot_slave.sv ***
// Functional notes
// - Master starts transfers only on idle bus
// - Data changes only while clock low
// - Data change with clock high is condition
// - Master starts transfers and makes clock
// - Device never drives clock, never starts
// - Start is data fall, clock high
// - Ignore the bus until a start
// - Stop is data rise, clock high
// - Master ends every operation with stop
// - Non-volatile write finishes within 5 ms
// - Busy writing: released data, no address ack
// - Master waits 1 ms after power-up
// - Wiper moves within 10 us of instruction
// - Wiper at power-up value within 10 us
// - Address low nibble must match pins
// - Receiver acknowledges each byte, ninth clock
// - No master ack ends reading; await stop
// - Non-volatile write starts at closing stop
`timescale 1ns/1ns
module pot_slave #(
    parameter int NV_WRITE_CYC = pot_link_pkg::NONVOLATILE_WRITE_CYCLE_CYC
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic link_clk,
    pot_bus_if.dev bus,
    input wire logic [3:0] hardwired_address_pins,
    output logic [7:0] wiper,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic nv_busy
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NV_WRITE_CYC < 1) begin : g_bad_nv
        $error("NV_WRITE_CYC must be at least one cycle");
    end
    if (pot_link_pkg::WIPER_RESPONSE_CYC < pot_link_pkg::WIPER_CROSS_CYC) begin : g_bad_wiper
        $error("wiper crossing slower than the wiper response time");
    end

    localparam int NW = $clog2(NV_WRITE_CYC + 1);

    // ------------------------------------------------------------
    // Link domain: reset and line synchronisers
    // ------------------------------------------------------------
    logic lrst_a_r;
    logic lrst_b_r;
    logic scl_a_r;
    logic scl_b_r;
    logic scl_c_r;
    logic sda_a_r;
    logic sda_b_r;
    logic sda_c_r;
    logic [3:0] pins_a_r;
    logic [3:0] pins_b_r;
    logic busy_a_r;
    logic busy_b_r;

    always_ff @(posedge link_clk) begin
        lrst_a_r <= resetn;
        lrst_b_r <= lrst_a_r;
    end

    always_ff @(posedge link_clk) begin
        scl_a_r <= bus.scl;
        scl_b_r <= scl_a_r;
        scl_c_r <= scl_b_r;
        sda_a_r <= bus.sda;
        sda_b_r <= sda_a_r;
        sda_c_r <= sda_b_r;
        pins_a_r <= hardwired_address_pins;
        pins_b_r <= pins_a_r;
        busy_a_r <= nv_busy;
        busy_b_r <= busy_a_r;
    end

    // Edges only from the second and third stages
    wire scl_rise = scl_b_r && !scl_c_r;
    wire scl_fall = !scl_b_r && scl_c_r;
    wire clk_high = scl_b_r && scl_c_r;
    wire start_cond = clk_high && sda_c_r && !sda_b_r;
    wire stop_cond = clk_high && !sda_c_r && sda_b_r;

    // ------------------------------------------------------------
    // Link domain: byte engine
    // ------------------------------------------------------------
    pot_link_pkg::dev_state_t st_r;
    pot_link_pkg::dev_state_t st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [1:0] byte_r;
    logic [1:0] byte_nxt;
    logic [7:0] instr_r;
    logic [7:0] instr_nxt;
    logic [7:0] hold_r;
    logic [7:0] hold_nxt;
    logic oe_r;
    logic oe_nxt;
    logic mack_r;
    logic mack_nxt;
    logic nv_arm_r;
    logic nv_arm_nxt;
    logic nv_pend_r;
    logic nv_pend_nxt;
    logic rx_tgl_r;
    logic rx_tgl_nxt;
    logic nv_tgl_r;
    logic nv_tgl_nxt;
    logic sda_o_r;

    // Pending covers the gap until the busy level has crossed back
    wire bus_blocked = busy_b_r || nv_pend_r;
    wire addr_hit = (sh_r == {pot_link_pkg::DEVICE_TYPE_CODE, pins_b_r}) && !bus_blocked;
    wire byte_full = (cnt_r == pot_link_pkg::BYTE_BITS);
    wire read_next = (byte_r == pot_link_pkg::BYTE_INSTR) && pot_link_pkg::instr_is_read(instr_r);
    wire [3:0] cnt_inc = cnt_r + 4'h1;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        byte_nxt = byte_r;
        instr_nxt = instr_r;
        hold_nxt = hold_r;
        oe_nxt = oe_r;
        mack_nxt = mack_r;
        nv_arm_nxt = nv_arm_r;
        nv_pend_nxt = nv_pend_r && !busy_b_r;
        rx_tgl_nxt = rx_tgl_r;
        nv_tgl_nxt = nv_tgl_r;
        if (start_cond) begin
            st_nxt = pot_link_pkg::DEV_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
            nv_arm_nxt = 1'b0;
        end else if (stop_cond) begin
            st_nxt = pot_link_pkg::DEV_IDLE;
            oe_nxt = 1'b0;
            nv_arm_nxt = 1'b0;
            if (nv_arm_r) begin
                nv_tgl_nxt = !nv_tgl_r;
                nv_pend_nxt = 1'b1;
            end
        end else begin
            unique case (st_r)
                pot_link_pkg::DEV_IDLE: begin
                    st_nxt = pot_link_pkg::DEV_IDLE;
                end
                pot_link_pkg::DEV_ADDR, pot_link_pkg::DEV_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_b_r};
                        cnt_nxt = cnt_inc;
                    end else if (scl_fall && byte_full) begin
                        st_nxt = pot_link_pkg::DEV_WAIT;
                        if (st_r == pot_link_pkg::DEV_ADDR) begin
                            if (addr_hit) begin
                                st_nxt = pot_link_pkg::DEV_ACK;
                                oe_nxt = 1'b1;
                                byte_nxt = pot_link_pkg::BYTE_ADDR;
                            end
                        end else if (byte_r == pot_link_pkg::BYTE_INSTR) begin
                            st_nxt = pot_link_pkg::DEV_ACK;
                            oe_nxt = 1'b1;
                            instr_nxt = sh_r;
                        end else if (byte_r == pot_link_pkg::BYTE_DATA) begin
                            st_nxt = pot_link_pkg::DEV_ACK;
                            oe_nxt = 1'b1;
                            hold_nxt = sh_r;
                            rx_tgl_nxt = !rx_tgl_r;
                            nv_arm_nxt = pot_link_pkg::instr_is_nv(instr_r);
                        end
                    end
                end
                pot_link_pkg::DEV_ACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        cnt_nxt = 4'h0;
                        byte_nxt = byte_r + 2'h1;
                        st_nxt = pot_link_pkg::DEV_RX;
                        if (read_next) begin
                            st_nxt = pot_link_pkg::DEV_TX;
                            sh_nxt = hold_r;
                            oe_nxt = !hold_r[7];
                        end
                    end
                end
                pot_link_pkg::DEV_TX: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_inc;
                    end else if (scl_fall) begin
                        if (byte_full) begin
                            st_nxt = pot_link_pkg::DEV_TXACK;
                            oe_nxt = 1'b0;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = !sh_r[6];
                        end
                    end
                end
                pot_link_pkg::DEV_TXACK: begin
                    if (scl_rise) begin
                        mack_nxt = !sda_b_r;
                    end else if (scl_fall) begin
                        st_nxt = pot_link_pkg::DEV_WAIT;
                        if (mack_r) begin
                            st_nxt = pot_link_pkg::DEV_TX;
                            cnt_nxt = 4'h0;
                            sh_nxt = hold_r;
                            oe_nxt = !hold_r[7];
                        end
                    end
                end
                pot_link_pkg::DEV_WAIT: begin
                    oe_nxt = 1'b0;
                end
                default: begin
                    st_nxt = pot_link_pkg::DEV_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lrst_b_r) begin
            st_r <= pot_link_pkg::DEV_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            byte_r <= pot_link_pkg::BYTE_INSTR;
            instr_r <= 8'h00;
            hold_r <= pot_link_pkg::WIPER_RESET_VALUE;
            oe_r <= 1'b0;
            mack_r <= 1'b0;
            nv_arm_r <= 1'b0;
            nv_pend_r <= 1'b0;
            rx_tgl_r <= 1'b0;
            nv_tgl_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            byte_r <= byte_nxt;
            instr_r <= instr_nxt;
            hold_r <= hold_nxt;
            oe_r <= oe_nxt;
            mack_r <= mack_nxt;
            nv_arm_r <= nv_arm_nxt;
            nv_pend_r <= nv_pend_nxt;
            rx_tgl_r <= rx_tgl_nxt;
            nv_tgl_r <= nv_tgl_nxt;
        end
    end

    // Only ever pulls data low; the clock line is only an input here
    always_ff @(posedge link_clk) begin
        sda_o_r <= 1'b0;
    end

    assign bus.dev_sda_o = sda_o_r;
    assign bus.dev_sda_oe = oe_r;

    // ------------------------------------------------------------
    // System domain: received byte and write cycle timer
    // ------------------------------------------------------------
    logic [2:0] rx_sync_r;
    logic [2:0] nv_sync_r;
    logic [NW-1:0] nv_cnt_r;
    logic [7:0] wiper_r;
    logic rx_valid_r;
    logic [7:0] rx_data_r;
    logic nv_busy_r;

    // Cleared in reset, so the link side's own reset of a toggle is no event
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rx_sync_r <= 3'h0;
            nv_sync_r <= 3'h0;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], rx_tgl_r};
            nv_sync_r <= {nv_sync_r[1:0], nv_tgl_r};
        end
    end

    wire rx_evt = rx_sync_r[2] ^ rx_sync_r[1];
    wire nv_evt = nv_sync_r[2] ^ nv_sync_r[1];
    wire nv_last = (nv_cnt_r == NW'(1));

    // hold_r is stable for many link cycles after its toggle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wiper_r <= pot_link_pkg::WIPER_RESET_VALUE;
            rx_valid_r <= 1'b0;
            rx_data_r <= 8'h00;
        end else begin
            rx_valid_r <= rx_evt;
            if (rx_evt) begin
                wiper_r <= hold_r;
                rx_data_r <= hold_r;
            end
        end
    end

    // A new write event wins over the end of the previous one
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            nv_busy_r <= 1'b0;
            nv_cnt_r <= '0;
        end else if (nv_evt) begin
            nv_busy_r <= 1'b1;
            nv_cnt_r <= NW'(NV_WRITE_CYC);
        end else if (nv_busy_r) begin
            nv_cnt_r <= nv_cnt_r - NW'(1);
            if (nv_last) begin
                nv_busy_r <= 1'b0;
            end
        end
    end

    assign wiper = wiper_r;
    assign rx_valid = rx_valid_r;
    assign rx_data = rx_data_r;
    assign nv_busy = nv_busy_r;

endmodule // pot_slave

// *** hdl/pot_link_pkg.sv ***
package pot_link_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 20;
    localparam int SCL_MAX_FREQ_KHZ = 400;
    // Quarter of the fastest legal serial clock period, rounded up
    localparam int SCL_QUARTER_CYC = (1_000_000 / SCL_MAX_FREQ_KHZ + 4 * SYS_CLK_PERIOD_NS - 1)
                                     / (4 * SYS_CLK_PERIOD_NS);
    localparam int NONVOLATILE_WRITE_CYCLE_TIME_MS = 5;
    localparam int NONVOLATILE_WRITE_CYCLE_CYC = NONVOLATILE_WRITE_CYCLE_TIME_MS * 1_000_000
                                                 / SYS_CLK_PERIOD_NS;
    localparam int POWERUP_TO_READ_DELAY_MS = 1;
    localparam int POWERUP_TO_WRITE_DELAY_MS = 1;
    localparam int POWERUP_DELAY_MS = (POWERUP_TO_READ_DELAY_MS > POWERUP_TO_WRITE_DELAY_MS) ?
                                      POWERUP_TO_READ_DELAY_MS : POWERUP_TO_WRITE_DELAY_MS;
    localparam int POWERUP_DELAY_CYC = (POWERUP_DELAY_MS * 1_000_000 + SYS_CLK_PERIOD_NS - 1)
                                       / SYS_CLK_PERIOD_NS;
    localparam int WIPER_RESPONSE_AFTER_INSTRUCTION_US = 10;
    localparam int WIPER_RESPONSE_AFTER_POWER_US = 10;
    localparam int WIPER_RESPONSE_CYC = WIPER_RESPONSE_AFTER_INSTRUCTION_US * 1000
                                        / SYS_CLK_PERIOD_NS;
    // Worst crossing latency of a received byte into the system domain
    localparam int WIPER_CROSS_CYC = 8;

    // ------------------------------------------------------------
    // Addressing and byte layout
    // ------------------------------------------------------------
    // Arbitrary device type code, not taken from any real part
    localparam logic [3:0] DEVICE_TYPE_CODE = 4'hA;
    localparam logic [7:0] WIPER_RESET_VALUE = 8'h80;
    localparam int INSTR_READ_BIT = 7;
    localparam int INSTR_NV_BIT = 6;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] BYTE_ADDR = 2'h3;
    localparam logic [1:0] BYTE_INSTR = 2'h0;
    localparam logic [1:0] BYTE_DATA = 2'h1;
    localparam logic [1:0] BYTE_DONE = 2'h2;

    typedef enum logic [2:0] {
        DEV_IDLE = 3'h0,
        DEV_ADDR = 3'h1,
        DEV_ACK = 3'h2,
        DEV_RX = 3'h3,
        DEV_TX = 3'h4,
        DEV_TXACK = 3'h5,
        DEV_WAIT = 3'h6
    } dev_state_t;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'h0,
        HOST_START = 2'h1,
        HOST_BIT = 2'h2,
        HOST_STOP = 2'h3
    } host_state_t;

    function automatic logic instr_is_read(input logic [7:0] instr);
        return instr[INSTR_READ_BIT];
    endfunction

    function automatic logic instr_is_nv(input logic [7:0] instr);
        return instr[INSTR_NV_BIT];
    endfunction

endpackage

// *** hdl/pot_bus_if.sv ***
`timescale 1ns/1ns
interface pot_bus_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: low only where someone drives a zero
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport host (
        output host_scl_o,
        output host_scl_oe,
        output host_sda_o,
        output host_sda_oe,
        input scl,
        input sda
    );

    modport dev (
        output dev_sda_o,
        output dev_sda_oe,
        input scl,
        input sda
    );
endinterface

// *** hdl/pot_master.sv ***
`timescale 1ns/1ns
module pot_master #(
    parameter int QTR_CYC = pot_link_pkg::SCL_QUARTER_CYC,
    parameter int POWERUP_CYC = pot_link_pkg::POWERUP_DELAY_CYC,
    parameter int FIFO_W = 20
) (
    input wire logic sys_clk,
    input wire logic resetn,
    pot_bus_if.host bus,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [3:0] cmd_addr,
    input wire logic [7:0] cmd_instr,
    input wire logic [7:0] cmd_data,
    output logic rsp_valid,
    output logic rsp_ack,
    output logic [7:0] rsp_data
);

    if (QTR_CYC < 2 || POWERUP_CYC < 1 || FIFO_W != 20) begin : g_bad
        $error("pot_master parameters out of range");
    end

    localparam int TW = $clog2(QTR_CYC);
    localparam int PW = $clog2(POWERUP_CYC + 1);

    // ------------------------------------------------------------
    // Two-entry command buffer
    // ------------------------------------------------------------
    logic [FIFO_W-1:0] mem_r [0:1];
    logic wp_r;
    logic rp_r;
    logic [1:0] fill_r;
    logic ready_r;
    logic [PW-1:0] pwr_cnt_r;
    logic pwr_done_r;
    pot_link_pkg::host_state_t st_r;

    wire push = cmd_valid && ready_r;
    wire pop = (st_r == pot_link_pkg::HOST_IDLE) && (fill_r != 2'h0) && pwr_done_r;
    wire [1:0] fill_nxt = fill_r + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            fill_r <= 2'h0;
            ready_r <= 1'b0;
        end else begin
            wp_r <= wp_r ^ push;
            rp_r <= rp_r ^ pop;
            fill_r <= fill_nxt;
            ready_r <= (fill_nxt != 2'h2);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_r[wp_r] <= {cmd_addr, cmd_instr, cmd_data};
        end
    end

    // No transfer until the device has had its power-up time
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pwr_cnt_r <= PW'(POWERUP_CYC);
            pwr_done_r <= 1'b0;
        end else if (!pwr_done_r) begin
            pwr_cnt_r <= pwr_cnt_r - PW'(1);
            pwr_done_r <= (pwr_cnt_r == PW'(1));
        end
    end

    // ------------------------------------------------------------
    // Bit engine: four quarters per serial clock period
    // ------------------------------------------------------------
    logic sda_a_r;
    logic sda_b_r;
    logic [TW-1:0] tick_r;
    logic [1:0] q_r;
    logic [3:0] bit_r;
    logic [1:0] byte_r;
    logic [FIFO_W-1:0] cur_r;
    logic [7:0] sh_r;
    logic nack_r;
    logic ack_ok_r;
    logic scl_oe_r;
    logic sda_oe_r;
    logic rsp_valid_r;

    always_ff @(posedge sys_clk) begin
        sda_a_r <= bus.sda;
        sda_b_r <= sda_a_r;
    end

    wire qstep = (tick_r == TW'(QTR_CYC - 1));
    wire rd = pot_link_pkg::instr_is_read(cur_r[15:8]);
    wire rd_byte = rd && (byte_r == pot_link_pkg::BYTE_DONE);
    wire last_byte = (byte_r == pot_link_pkg::BYTE_DONE) || (nack_r && !rd_byte);
    wire [7:0] next_byte = (byte_r == 2'h0) ? cur_r[15:8] : cur_r[7:0];
    wire [7:0] addr_byte = {pot_link_pkg::DEVICE_TYPE_CODE, cur_r[19:16]};

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_r <= pot_link_pkg::HOST_IDLE;
            tick_r <= '0;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
            cur_r <= '0;
            sh_r <= 8'h00;
            nack_r <= 1'b0;
            ack_ok_r <= 1'b0;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            rsp_valid_r <= 1'b0;
        end else begin
            rsp_valid_r <= 1'b0;
            tick_r <= (qstep || st_r == pot_link_pkg::HOST_IDLE) ? '0 : tick_r + TW'(1);
            if (pop) begin
                st_r <= pot_link_pkg::HOST_START;
                q_r <= 2'h0;
                cur_r <= mem_r[rp_r];
                ack_ok_r <= 1'b1;
            end else if (qstep) begin
                q_r <= q_r + 2'h1;
                unique case (st_r)
                    pot_link_pkg::HOST_START: begin
                        if (q_r == 2'h1) sda_oe_r <= 1'b1;
                        if (q_r == 2'h2) scl_oe_r <= 1'b1;
                        if (q_r == 2'h3) begin
                            st_r <= pot_link_pkg::HOST_BIT;
                            bit_r <= 4'h0;
                            byte_r <= 2'h0;
                            sh_r <= addr_byte;
                            sda_oe_r <= !addr_byte[7];
                        end
                    end
                    pot_link_pkg::HOST_BIT: begin
                        if (q_r == 2'h0) scl_oe_r <= 1'b0;
                        if (q_r == 2'h1) begin
                            if (bit_r == 4'h8) nack_r <= sda_b_r;
                            else sh_r <= {sh_r[6:0], sda_b_r};
                        end
                        if (q_r == 2'h2) scl_oe_r <= 1'b1;
                        if (q_r == 2'h3) begin
                            if (bit_r != 4'h8) begin
                                bit_r <= bit_r + 4'h1;
                                sda_oe_r <= (bit_r != 4'h7) && !rd_byte && !sh_r[7];
                            end else if (last_byte) begin
                                st_r <= pot_link_pkg::HOST_STOP;
                                sda_oe_r <= 1'b1;
                                if (nack_r && !rd_byte) ack_ok_r <= 1'b0;
                            end else begin
                                bit_r <= 4'h0;
                                byte_r <= byte_r + 2'h1;
                                sh_r <= next_byte;
                                sda_oe_r <= !(rd && byte_r == 2'h1) && !next_byte[7];
                            end
                        end
                    end
                    pot_link_pkg::HOST_STOP: begin
                        if (q_r == 2'h0) scl_oe_r <= 1'b0;
                        if (q_r == 2'h1) sda_oe_r <= 1'b0;
                        if (q_r == 2'h3) begin
                            st_r <= pot_link_pkg::HOST_IDLE;
                            rsp_valid_r <= 1'b1;
                        end
                    end
                    default: begin
                        st_r <= pot_link_pkg::HOST_IDLE;
                    end
                endcase
            end
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_scl_oe = scl_oe_r;
    assign bus.host_sda_oe = sda_oe_r;
    assign cmd_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_ack = ack_ok_r;
    assign rsp_data = sh_r;

endmodule // pot_master

// *** sim/pot_link_properties.sv ***
`timescale 1ns/1ns
module pot_link_properties #(
    parameter int POWERUP_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic nv_busy
);
    // ----
    // Bus tracking from the resolved wires
    // ----
    logic scl_q, sda_q, busy_r;
    logic [15:0] pu_cnt, bz_cnt;
    wire start_w = scl_q && scl && sda_q && !sda;
    wire stop_w = scl_q && scl && !sda_q && sda;
    always_ff @(posedge sys_clk) begin
        scl_q <= scl;
        sda_q <= sda;
        busy_r <= resetn && (start_w || (busy_r && !stop_w));
        pu_cnt <= !resetn ? 16'h0 : pu_cnt + {15'h0, !pu_cnt[15]};
        bz_cnt <= busy_r ? bz_cnt + 16'h1 : 16'h0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_start_when_idle: assert property (start_w |-> !busy_r) else $error("start on busy bus");
    a_scl_idle_high: assert property (!busy_r |-> !host_scl_oe) else $error("clock held idle");
    a_pull_low_only: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
        else $error("line driven high");
    a_dev_data_stable: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device data moved with clock high");
    a_dev_quiet_idle: assert property (!busy_r |-> !dev_sda_oe) else $error("device drives idle");
    a_busy_no_ack: assert property (nv_busy |-> !dev_sda_oe) else $error("drive while busy");
    // First host drive comes two quarters after the power-up wait has ended
    a_powerup_quiet: assert property (pu_cnt < POWERUP_CYC + 2 * pot_link_pkg::SCL_QUARTER_CYC - 4
        |-> !host_sda_oe && !host_scl_oe)
        else $error("bus used before power-up wait");
    a_transfer_bounded: assert property (bz_cnt < 16'h1770) else $error("no closing stop");
    a_ack_scl_low: assert property ($rose(dev_sda_oe) |-> !scl [*8]) else $error("ack timing");
    c_start: cover property (start_w);
    c_stop: cover property (stop_w);
    c_nv: cover property ($rose(nv_busy));
endmodule // pot_link_properties

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    localparam int PU = 20;
    // Row: pins, addr, instr, data, ack, expected byte
    localparam logic [32:0] ROWS [4] = '{
        {4'h5, 4'h5, 8'h00, 8'h3C, 1'b1, 8'h3C},
        {4'h5, 4'h5, 8'h80, 8'h00, 1'b1, 8'h3C},
        {4'h9, 4'h5, 8'h00, 8'h77, 1'b0, 8'h3C},
        {4'h9, 4'h9, 8'h00, 8'hC3, 1'b1, 8'hC3}};
    logic sys_clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0;
    logic cmd_ready, rsp_valid, rsp_ack, rx_valid, nv_busy;
    logic [3:0] pins = 4'h5, cmd_addr = 4'h0;
    logic [7:0] cmd_instr = 8'h00, cmd_data = 8'h00, rsp_data, wiper, rx_data;
    int n_errors = 0, cmp_count = 0, cyc = 0, rx_n = 0, k;
    pot_bus_if bus_i ();
    pot_master #(.POWERUP_CYC(PU)) pot_master_i (.sys_clk(sys_clk), .resetn(resetn),
        .bus(bus_i.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
        .cmd_instr(cmd_instr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
        .rsp_data(rsp_data));
    pot_slave #(.NV_WRITE_CYC(2000)) pot_slave_i (.sys_clk(sys_clk), .resetn(resetn),
        .link_clk(link_clk), .bus(bus_i.dev), .hardwired_address_pins(pins), .wiper(wiper),
        .rx_valid(rx_valid), .rx_data(rx_data), .nv_busy(nv_busy));
    pot_link_properties #(.POWERUP_CYC(PU)) props_i (.sys_clk(sys_clk), .resetn(resetn),
        .link_clk(link_clk), .host_scl_o(bus_i.host_scl_o), .host_scl_oe(bus_i.host_scl_oe),
        .host_sda_o(bus_i.host_sda_o), .host_sda_oe(bus_i.host_sda_oe), .scl(bus_i.scl),
        .dev_sda_o(bus_i.dev_sda_o), .dev_sda_oe(bus_i.dev_sda_oe), .sda(bus_i.sda),
        .nv_busy(nv_busy));
    initial forever #10 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (rx_valid === 1'b1) rx_n++;
        if (cyc == 40000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Valid stays up on return, so two pushes may follow each other
    task automatic push(input logic [3:0] a, input logic [7:0] i, input logic [7:0] d);
        cmd_addr = a;
        cmd_instr = i;
        cmd_data = d;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic wait_rsp(input logic exp_ack);
        @(negedge sys_clk);
        for (k = 0; k < 9000 && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
        check("rsp_valid", {7'h0, rsp_valid}, 8'h01);
        check("rsp_ack", {7'h0, rsp_ack}, {7'h0, exp_ack});
    endtask
    task automatic conclude;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        // Longer than three cycles: the link side needs three of its own edges
        repeat (14) @(negedge sys_clk);
        resetn = 1'b1;
        check("wiper", wiper, 8'h80);
        @(negedge sys_clk);
        check("cmd_ready", {7'h0, cmd_ready}, 8'h01);
        for (int r = 0; r < 4; r++) begin
            pins = ROWS[r][32:29];
            push(ROWS[r][28:25], ROWS[r][24:17], ROWS[r][16:9]);
            cmd_valid = 1'b0;
            wait_rsp(ROWS[r][8]);
            check("wiper", wiper, ROWS[r][7:0]);
            check("rx_data", rx_data, ROWS[r][7:0]);
            if (ROWS[r][24]) check("rsp_data", rsp_data, ROWS[r][7:0]);
        end
        push(4'h9, 8'h40, 8'h5A);
        push(4'h9, 8'h00, 8'h11);
        cmd_valid = 1'b0;
        wait_rsp(1'b1);
        check("nv_busy", {7'h0, nv_busy}, 8'h01);
        wait_rsp(1'b0);
        check("wiper", wiper, 8'h5A);
        for (k = 0; k < 3000 && nv_busy !== 1'b0; k++) @(negedge sys_clk);
        check("nv_busy", {7'h0, nv_busy}, 8'h00);
        push(4'h9, 8'h00, 8'h99);
        cmd_valid = 1'b0;
        wait_rsp(1'b1);
        check("wiper", wiper, 8'h99);
        // Mid-run reset: master refuses commands, wiper back to power-up value
        resetn = 1'b0;
        repeat (14) @(negedge sys_clk);
        check("cmd_ready", {7'h0, cmd_ready}, 8'h00);
        check("nv_busy", {7'h0, nv_busy}, 8'h00);
        resetn = 1'b1;
        check("wiper", wiper, 8'h80);
        push(4'h9, 8'h00, 8'h42);
        cmd_valid = 1'b0;
        wait_rsp(1'b1);
        check("wiper", wiper, 8'h42);
        check("rx_count", 8'(rx_n), 8'h05);
        conclude();
    end
endmodule // testbench
